/* File: dma_channel_seq.sv */
// one dma channel: descriptor fetch, transfer, done-bit writeback
`timescale 1ns/10ps
`include "image_dma_defs.svh"
module dma_channel_seq
   import image_dma_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic srst, // sync reset
   input wire logic fetchEn, // fetch enable
   input wire logic wbEn, // writeback enable
   input wire logic doneFlagDis, // done flag suppress
   input wire logic [31:0] descBase, // descriptor base
   input wire logic start, // start pulse
   input wire logic xferEnd, // end of frame transfer
   output logic doneFlag, // done pulse
   output logic busy, // channel active
   dma_mem_if.chan mem // memory requests
);
   ch_state_t state;
   ch_state_t next_state;
   logic [31:0] wordAddr;
   assign wordAddr = {descBase[31:2], 2'b00};
   always_comb
   begin
      next_state = state;
      case (state)
         CH_IDLE: if (start && fetchEn) next_state = CH_FETCH;
         CH_FETCH: if (!fetchEn) next_state = CH_IDLE;
            else if (mem.ack) next_state = CH_XFER;
         CH_XFER: if (xferEnd) next_state = wbEn ? CH_WBACK : CH_IDLE;
         CH_WBACK: if (mem.ack) next_state = CH_IDLE;
         default: next_state = CH_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst) state <= CH_IDLE;
      else state <= next_state;
   end
   // fetch only while enabled; writeback sets done bit in memory only
   assign mem.req = (state == CH_FETCH && fetchEn) || state == CH_WBACK;
   assign mem.wr = (state == CH_WBACK);
   assign mem.addr = wordAddr;
   assign mem.wdata = 32'h00000001 << `BIT_DONE;
   assign busy = (state != CH_IDLE);
   always_ff @(posedge ref_clk)
   begin
      if (srst) doneFlag <= 1'b0;
      else doneFlag <= (state == CH_XFER) && xferEnd && !doneFlagDis;
   end
   AST_NOFETCH: assert property (@(posedge ref_clk) disable iff (srst)
      (mem.req && !mem.wr) |-> fetchEn && $past(fetchEn)
         && state == CH_FETCH)
      else $error("fetch while disabled");
   AST_NOWB: assert property (@(posedge ref_clk) disable iff (srst)
      (state == CH_XFER && xferEnd && !wbEn) |=> state == CH_IDLE)
      else $error("writeback while disabled");
   AST_DONEFLAG: assert property (@(posedge ref_clk) disable iff (srst)
      (state == CH_XFER && xferEnd) |=> doneFlag == !$past(doneFlagDis))
      else $error("done flag wrong");
endmodule : dma_channel_seq

/* File: dma_mem_if.sv */
// memory request carrier between control and channel sequencer
`timescale 1ns/10ps
interface dma_mem_if;
   logic req;
   logic wr;
   logic [31:0] addr;
   logic [31:0] wdata;
   logic ack;
   modport chan (output req, output wr, output addr, output wdata,
      input ack);
   modport top (input req, input wr, input addr, input wdata,
      output ack);
endinterface : dma_mem_if

/* File: image_dma_defs.svh */
// register offsets, field positions and constants of the image dma block
`ifndef IMAGE_DMA_DEFS_SVH
`define IMAGE_DMA_DEFS_SVH
`define OFS_PREV_CTRL 8'h00
`define OFS_PREV_DESC 8'h04
`define OFS_COD_ADDR 8'h08
`define OFS_COD_CTRL 8'h0C
`define OFS_COD_DESC 8'h10
`define OFS_WP_CTRL 8'h14
`define OFS_WP_STAT 8'h18
`define OFS_CFG0 8'h20
`define OFS_CFG1 8'h24
`define OFS_CFG2 8'h28
`define OFS_CFG3 8'h2C
`define OFS_SWRST 8'h30
`define OFS_STATUS 8'h34
`define BIT_FETCH 0
`define BIT_WB 1
`define BIT_DFDIS 2
`define BIT_DONE 3
`define BIT_WPEN 0
`define WP_KEY_LSB 8
`define WP_KEY_VAL 24'h495349
`define VSRC_LSB 8
`define VS_WRITE 4'h1
`define VS_RESET 4'h2
`define CTRL_RST 32'h00000000
`define ADDR_RST 32'h00000000
`endif

/* File: image_dma_desc_ctrl.sv */
// image dma descriptor control with key-guarded write protection
//
// Behaviour
// - preview fetches descriptors only when enabled
// - preview writeback only when enabled
// - preview done flag control is active low
// - preview done bit set in memory only
// - codec fetches descriptors only when enabled
// - codec writeback only when enabled
// - codec done flag control is active low
// - codec done bit written after transfer
// - preview descriptor address word aligned
// - codec image base word aligned
// - codec descriptor address word aligned
// - protect control write needs correct key
// - keyed enable bit sets protection on/off
// - status code 1 on blocked write
// - code 2 on reset while protected, 3 both
// - status read clears violation status
// - source field names blocked register
`timescale 1ns/10ps
`include "image_dma_defs.svh"
module image_dma_desc_ctrl
   import image_dma_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic srst, // sync reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read response valid
   input wire logic s_axi_rready, // read response ready
   input wire logic prevStart, // preview frame start
   input wire logic prevXferEnd, // preview transfer end
   input wire logic codStart, // codec frame start
   input wire logic codXferEnd, // codec transfer end
   output logic prevDoneFlag, // preview done pulse
   output logic codDoneFlag, // codec done pulse
   output logic memReq, // memory request
   output logic memWr, // memory write
   output logic [31:0] memAddr, // memory word address
   output logic [31:0] memWdata, // memory write data
   input wire logic memAck, // memory acknowledge
   output logic [31:0] codImageBase, // codec image base
   output logic [31:0] cfgOut0 // first protected config
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [3:0] prevCtrl;
   logic [3:0] codCtrl;
   logic [31:0] prevDescBase;
   logic [31:0] codDescBase;
   logic [31:0] codAddr;
   logic wpEnable;
   logic [3:0] violationStatus;
   logic [15:0] violationSource;
   logic [31:0] cfgReg [4];
   logic prevBusy;
   logic codBusy;
   // ----------------------------------------------------------------
   // axi write channel
   // ----------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic doWrite;
   logic [31:0] merged;
   logic keyOk;
   logic isCfg;
   logic [1:0] cfgIdx;
   logic cfgBlocked;
   logic swReset;
   logic [31:0] resetWord;
   function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
      input logic [31:0] newV, input logic [3:0] strb);
      logic [31:0] r;
      r = oldV;
      for (int i = 0; i < 4; i++)
         if (strb[i]) r[i*8 +: 8] = newV[i*8 +: 8];
      return r;
   endfunction : mergeBytes
   function automatic logic [31:0] alignWord(input logic [31:0] v);
      return {v[31:2], 2'b00};
   endfunction : alignWord
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign doWrite = awHeld && wHeld && !s_axi_bvalid;
   assign merged = mergeBytes(32'h00000000, wData, wStrb);
   assign keyOk = merged[31:`WP_KEY_LSB] == `WP_KEY_VAL;
   assign isCfg = awAddr >= `OFS_CFG0 && awAddr <= `OFS_CFG3;
   assign cfgIdx = awAddr[3:2];
   assign cfgBlocked = doWrite && isCfg && wpEnable;
   assign swReset = doWrite && awAddr == `OFS_SWRST && wData[0];
   assign resetWord = `ADDR_RST;
   // ----------------------------------------------------------------
   // control word merge
   // ----------------------------------------------------------------
   // done bit is dropped here: it only ever lives in memory
   logic [31:0] prevCtrlNew;
   logic [31:0] codCtrlNew;
   assign prevCtrlNew = mergeBytes({28'h0, prevCtrl}, wData, wStrb);
   assign codCtrlNew = mergeBytes({28'h0, codCtrl}, wData, wStrb);
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end
         else if (s_axi_bready) s_axi_bvalid <= 1'b0;
      end
   end
   assign s_axi_bresp = 2'b00;
   // ----------------------------------------------------------------
   // register updates
   // ----------------------------------------------------------------
   // software reset returns dma settings to defaults but keeps protection
   always_ff @(posedge ref_clk)
   begin
      if (srst || swReset)
      begin
         prevCtrl <= 4'h0;
         codCtrl <= 4'h0;
         prevDescBase <= `ADDR_RST;
         codDescBase <= `ADDR_RST;
         codAddr <= `ADDR_RST;
      end
      else if (doWrite)
      begin
         case (awAddr)
            `OFS_PREV_CTRL: prevCtrl <= {1'b0, prevCtrlNew[2:0]};
            `OFS_COD_CTRL: codCtrl <= {1'b0, codCtrlNew[2:0]};
            `OFS_PREV_DESC: prevDescBase <=
               alignWord(mergeBytes(prevDescBase, wData, wStrb));
            `OFS_COD_ADDR: codAddr <=
               alignWord(mergeBytes(codAddr, wData, wStrb));
            `OFS_COD_DESC: codDescBase <=
               alignWord(mergeBytes(codDescBase, wData, wStrb));
            default: ;
         endcase
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         for (int i = 0; i < 4; i++) cfgReg[i] <= resetWord;
         wpEnable <= 1'b0;
      end
      else if (doWrite)
      begin
         if (isCfg && !wpEnable)
            cfgReg[cfgIdx] <= mergeBytes(cfgReg[cfgIdx], wData, wStrb);
         if (awAddr == `OFS_WP_CTRL && keyOk)
            wpEnable <= wData[`BIT_WPEN];
      end
   end
   // ----------------------------------------------------------------
   // read channel and violation tracking
   // ----------------------------------------------------------------
   logic [31:0] readMux;
   logic statRead;
   assign s_axi_arready = !s_axi_rvalid;
   assign statRead = s_axi_arvalid && s_axi_arready
      && s_axi_araddr == `OFS_WP_STAT;
   always_comb
   begin
      case (s_axi_araddr)
         `OFS_PREV_CTRL: readMux = {28'h0, prevCtrl};
         `OFS_PREV_DESC: readMux = prevDescBase;
         `OFS_COD_ADDR: readMux = codAddr;
         `OFS_COD_CTRL: readMux = {28'h0, codCtrl};
         `OFS_COD_DESC: readMux = codDescBase;
         `OFS_WP_CTRL: readMux = {31'h0, wpEnable};
         `OFS_WP_STAT: readMux = {8'h00, violationSource, 4'h0,
            violationStatus};
         `OFS_CFG0: readMux = cfgReg[0];
         `OFS_CFG1: readMux = cfgReg[1];
         `OFS_CFG2: readMux = cfgReg[2];
         `OFS_CFG3: readMux = cfgReg[3];
         `OFS_STATUS: readMux = {30'h0, codBusy, prevBusy};
         default: readMux = 32'h00000000;
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readMux;
      end
      else if (s_axi_rready) s_axi_rvalid <= 1'b0;
   end
   assign s_axi_rresp = 2'b00;
   // new events win over the clear from a status read
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         violationStatus <= 4'h0;
         violationSource <= 16'h0000;
      end
      else
      begin
         violationStatus <= (statRead ? 4'h0 : violationStatus)
            | (cfgBlocked ? `VS_WRITE : 4'h0)
            | (swReset && wpEnable ? `VS_RESET : 4'h0);
         if (cfgBlocked)
            violationSource <= {14'h0, cfgIdx} + 16'h0001;
         else if (statRead) violationSource <= 16'h0000;
      end
   end
   // ----------------------------------------------------------------
   // channels and memory arbitration
   // ----------------------------------------------------------------
   dma_mem_if prevMem();
   dma_mem_if codMem();
   dma_channel_seq u_prev (
      .ref_clk(ref_clk),
      .srst(srst),
      .fetchEn(prevCtrl[`BIT_FETCH]),
      .wbEn(prevCtrl[`BIT_WB]),
      .doneFlagDis(prevCtrl[`BIT_DFDIS]),
      .descBase(prevDescBase),
      .start(prevStart),
      .xferEnd(prevXferEnd),
      .doneFlag(prevDoneFlag),
      .busy(prevBusy),
      .mem(prevMem.chan)
   );
   dma_channel_seq u_cod (
      .ref_clk(ref_clk),
      .srst(srst),
      .fetchEn(codCtrl[`BIT_FETCH]),
      .wbEn(codCtrl[`BIT_WB]),
      .doneFlagDis(codCtrl[`BIT_DFDIS]),
      .descBase(codDescBase),
      .start(codStart),
      .xferEnd(codXferEnd),
      .doneFlag(codDoneFlag),
      .busy(codBusy),
      .mem(codMem.chan)
   );
   // preview has fixed priority; codec waits its turn
   // ack goes to whoever is selected when it lands, so memory must not
   // answer a codec request in the cycle preview raises its own
   logic selPrev;
   assign selPrev = prevMem.req;
   assign memReq = prevMem.req || codMem.req;
   assign memWr = selPrev ? prevMem.wr : codMem.wr;
   assign memAddr = selPrev ? prevMem.addr : codMem.addr;
   assign memWdata = selPrev ? prevMem.wdata : codMem.wdata;
   assign prevMem.ack = memAck && selPrev;
   assign codMem.ack = memAck && !selPrev;
   assign codImageBase = codAddr;
   assign cfgOut0 = cfgReg[0];
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_KEY: assert property (@(posedge ref_clk) disable iff (srst)
      (doWrite && awAddr == `OFS_WP_CTRL && !keyOk) |=> $stable(wpEnable))
      else $error("bad key changed protection");
   AST_WPEN: assert property (@(posedge ref_clk) disable iff (srst)
      (doWrite && awAddr == `OFS_WP_CTRL && keyOk)
      |=> wpEnable == $past(wData[0]))
      else $error("protect enable not taken");
   AST_VIOL: assert property (@(posedge ref_clk) disable iff (srst)
      cfgBlocked |=> violationStatus[0])
      else $error("violation not flagged");
   AST_RSTV: assert property (@(posedge ref_clk) disable iff (srst)
      (swReset && wpEnable) |=> violationStatus[1])
      else $error("reset violation not flagged");
   AST_CLR: assert property (@(posedge ref_clk) disable iff (srst)
      (statRead && !cfgBlocked && !swReset) |=> violationStatus == 4'h0)
      else $error("status not cleared");
   AST_SRC: assert property (@(posedge ref_clk) disable iff (srst)
      cfgBlocked |=> violationSource == {14'h0, $past(cfgIdx)} + 16'h1)
      else $error("wrong source code");
   AST_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
      cfgBlocked |=> cfgReg[$past(cfgIdx)] == $past(cfgReg[cfgIdx]))
      else $error("protected register changed");
   AST_ALIGN: assert property (@(posedge ref_clk) disable iff (srst)
      prevDescBase[1:0] == 2'b00 && codDescBase[1:0] == 2'b00)
      else $error("unaligned descriptor base");
   // ----------------------------------------------------------------
   // bus and memory checks
   // ----------------------------------------------------------------
   AST_BRISE: assert property (@(posedge ref_clk) disable iff (srst)
      doWrite |=> s_axi_bvalid && !awHeld && !wHeld)
      else $error("write response missing");
   AST_SWRST: assert property (@(posedge ref_clk) disable iff (srst)
      swReset |=> prevCtrl == 4'h0 && codCtrl == 4'h0)
      else $error("software reset left dma settings");
   AST_RDCLR: assert property (@(posedge ref_clk) disable iff (srst)
      (statRead && !cfgBlocked) |=> violationSource == 16'h0000)
      else $error("source not cleared by read");
   AST_BASEAL: assert property (@(posedge ref_clk) disable iff (srst)
      codAddr[1:0] == 2'b00)
      else $error("unaligned image base");
   AST_MEMAL: assert property (@(posedge ref_clk) disable iff (srst)
      (memReq && !memWr && !selPrev) |-> memAddr == codDescBase)
      else $error("codec fetch off its descriptor base");
endmodule : image_dma_desc_ctrl

/* File: image_dma_desc_ctrl_tb.sv */
// self-checking bench for the image dma descriptor control block
`timescale 1ns/10ps
`include "image_dma_defs.svh"
module image_dma_desc_ctrl_tb import image_dma_pkg::*;;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] ev = 4'h0;
   logic [3:0] memDelay = 4'h0;
   logic [3:0] wrStrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, prevDoneFlag, codDoneFlag, memReq, memWr, memAck;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, memAddr, memWdata, codImageBase, cfgOut0;
   int n_mismatch = 0;
   int checked = 0;
   int nPFlag = 0;
   int nCFlag = 0;

   always #2 ref_clk = ~ref_clk;

   image_dma_desc_ctrl dut (.ref_clk(ref_clk), .srst(srst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(wrStrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .prevStart(ev[0]),
      .prevXferEnd(ev[1]), .codStart(ev[2]), .codXferEnd(ev[3]),
      .prevDoneFlag(prevDoneFlag), .codDoneFlag(codDoneFlag),
      .memReq(memReq), .memWr(memWr), .memAddr(memAddr),
      .memWdata(memWdata), .memAck(memAck),
      .codImageBase(codImageBase), .cfgOut0(cfgOut0));

   image_dma_mem_model mem (.ref_clk(ref_clk), .srst(srst),
      .memReq(memReq), .memWr(memWr), .memAddr(memAddr),
      .memWdata(memWdata), .ackDelay(memDelay), .memAck(memAck));

   // done flags are one-cycle pulses, so count them at every edge
   always @(posedge ref_clk)
   begin
      if (prevDoneFlag === 1'b1)
         nPFlag++;
      if (codDoneFlag === 1'b1)
         nCFlag++;
   end

   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task automatic cmp(input string what, input word_t exp, input word_t got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %08X seen %08X", what, exp, got);
      end
   endtask : cmp

   task automatic axiWrite(input logic [7:0] a, input word_t d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      cmp("bresp", 32'h00000000, s_axi_bresp);
   endtask : axiWrite

   task automatic readCheck(input logic [7:0] a, input word_t exp,
      input string what);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp(what, exp, s_axi_rdata);
      cmp("rresp", 32'h00000000, s_axi_rresp);
   endtask : readCheck

   task automatic pulse(input int idx);
      @(posedge ref_clk);
      ev[idx] <= 1'b1;
      @(posedge ref_clk);
      ev[idx] <= 1'b0;
      repeat (30) @(posedge ref_clk);
   endtask : pulse

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic regReset;
      for (int i = 0; i < 8; i++)
         readCheck(8'(i * 4), 32'h00000000, "reset value");
      readCheck(`OFS_STATUS, 32'h00000000, "busy idle");
   endtask : regReset

   task automatic regAddr;
      axiWrite(`OFS_PREV_DESC, 32'h00001003);
      readCheck(`OFS_PREV_DESC, 32'h00001000, "prev desc");
      axiWrite(`OFS_COD_ADDR, 32'h00003001);
      readCheck(`OFS_COD_ADDR, 32'h00003000, "codec base");
      cmp("codec base out", 32'h00003000, codImageBase);
      wrStrb <= 4'h2;
      axiWrite(`OFS_COD_ADDR, 32'hFFFF55FF);
      wrStrb <= 4'hF;
      readCheck(`OFS_COD_ADDR, 32'h00005500, "codec base lane");
      axiWrite(`OFS_COD_DESC, 32'h00002002);
      readCheck(`OFS_COD_DESC, 32'h00002000, "codec desc");
      axiWrite(8'h3C, 32'hFFFFFFFF);
      readCheck(8'h3C, 32'h00000000, "unmapped");
   endtask : regAddr

   // done bit is written as 1 but must read back 0
   task automatic chanRun(input bit cod, input word_t ctrl, input int eF,
      input int eW, input int eFl);
      int f0;
      int w0;
      int g0;
      logic [7:0] a;
      f0 = mem.nFetch;
      w0 = mem.nWback;
      g0 = cod ? nCFlag : nPFlag;
      a = cod ? `OFS_COD_CTRL : `OFS_PREV_CTRL;
      axiWrite(a, ctrl | 32'h00000008);
      readCheck(a, ctrl, "control");
      pulse(cod ? 2 : 0);
      cmp("fetches", eF, mem.nFetch - f0);
      if (eF != 0)
      begin
         cmp("fetch addr", cod ? 32'h00002000 : 32'h00001000,
            mem.lastRdAddr);
         readCheck(`OFS_STATUS, cod ? 32'h00000002 : 32'h00000001, "busy");
      end
      else
         readCheck(`OFS_STATUS, 32'h00000000, "busy off");
      pulse(cod ? 3 : 1);
      cmp("writebacks", eW, mem.nWback - w0);
      if (eW != 0)
         cmp("done word", 32'h00000008, mem.lastWdata);
      cmp("done flags", eFl, (cod ? nCFlag : nPFlag) - g0);
   endtask : chanRun

   task automatic chanAll;
      chanRun(1'b0, 32'h00000003, 1, 1, 1);
      chanRun(1'b0, 32'h00000006, 0, 0, 0);
      chanRun(1'b0, 32'h00000005, 1, 0, 0);
      memDelay <= 4'h5;
      chanRun(1'b1, 32'h00000003, 1, 1, 1);
      chanRun(1'b1, 32'h00000006, 0, 0, 0);
      chanRun(1'b1, 32'h00000001, 1, 0, 1);
      chanRun(1'b1, 32'h00000007, 1, 1, 0);
   endtask : chanAll

   task automatic wpCheck;
      axiWrite(`OFS_WP_CTRL, 32'h12345601);
      axiWrite(`OFS_CFG0, 32'h00000022);
      cmp("cfg0 open", 32'h00000022, cfgOut0);
      readCheck(`OFS_WP_STAT, 32'h00000000, "status none");
      axiWrite(`OFS_WP_CTRL, {`WP_KEY_VAL, 8'h01});
      axiWrite(`OFS_CFG1, 32'h00000033);
      readCheck(`OFS_CFG1, 32'h00000000, "cfg1 guarded");
      readCheck(`OFS_WP_STAT, 32'h00000201, "status write");
      readCheck(`OFS_WP_STAT, 32'h00000000, "status read");
      axiWrite(`OFS_SWRST, 32'h00000001);
      axiWrite(`OFS_CFG0, 32'h00000044);
      cmp("cfg0 guarded", 32'h00000022, cfgOut0);
      readCheck(`OFS_WP_STAT, 32'h00000103, "status both");
      axiWrite(`OFS_SWRST, 32'h00000001);
      readCheck(`OFS_WP_STAT, 32'h00000002, "status reset");
      axiWrite(`OFS_WP_CTRL, {`WP_KEY_VAL, 8'h00});
      axiWrite(`OFS_CFG0, 32'h00000055);
      cmp("cfg0 reopened", 32'h00000055, cfgOut0);
      readCheck(`OFS_WP_STAT, 32'h00000000, "status off");
   endtask : wpCheck

   // ----------------------------------------
   // sequence, watchdog and verdict
   // ----------------------------------------
   task automatic results;
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : results

   initial
   begin
      repeat (8) @(posedge ref_clk);
      srst <= 1'b0;
      regReset();
      regAddr();
      chanAll();
      wpCheck();
      results();
   end

   // whole run needs about 650 cycles; the margin covers slow memory
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      results();
   end
endmodule : image_dma_desc_ctrl_tb

/* File: image_dma_mem_model.sv */
// system memory stand-in answering descriptor fetches and writebacks
`timescale 1ns/10ps
module image_dma_mem_model
(
   input wire logic ref_clk, // clock
   input wire logic srst, // sync reset
   input wire logic memReq, // request
   input wire logic memWr, // write
   input wire logic [31:0] memAddr, // word address
   input wire logic [31:0] memWdata, // write data
   input wire logic [3:0] ackDelay, // extra wait cycles
   output logic memAck // acknowledge pulse
);
   // ----------------------------------------
   // request log
   // ----------------------------------------
   int nFetch;
   int nWback;
   logic [31:0] lastRdAddr;
   logic [31:0] lastWdata;
   logic [3:0] waitCnt;

   // ----------------------------------------
   // answer after a programmable wait
   // ----------------------------------------
   // ack is a single pulse, so the request must be held until it lands
   always_ff @(posedge ref_clk)
   begin
      memAck <= 1'b0;
      if (srst)
      begin
         waitCnt <= 4'h0;
         nFetch <= 0;
         nWback <= 0;
      end
      else if (memReq && !memAck)
      begin
         if (waitCnt >= ackDelay)
         begin
            memAck <= 1'b1;
            waitCnt <= 4'h0;
            if (memWr)
            begin
               nWback <= nWback + 1;
               lastWdata <= memWdata;
            end
            else
            begin
               nFetch <= nFetch + 1;
               lastRdAddr <= memAddr;
            end
         end
         else
            waitCnt <= waitCnt + 4'h1;
      end
   end
endmodule : image_dma_mem_model

/* File: image_dma_pkg.sv */
// types shared by the image dma descriptor control block
package image_dma_pkg;
   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_FETCH = 2'b01,
      CH_XFER = 2'b11,
      CH_WBACK = 2'b10
   } ch_state_t;
   typedef logic [31:0] word_t;
endpackage : image_dma_pkg
